// [hdl/dnp_object_responder.sv]
// Purpose: application object responder of the meter's serial slave
// Assumes: one parsed request per strobe; datapath on the same clock
// Notes: responses leave as a stream of header, point and end items
`timescale 1ns/100ps
module dnp_object_responder
  import dnp_resp_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic i_REQ_VALID,
  input wire logic [7:0] i_REQ_FUNC,
  input wire logic [7:0] i_REQ_OBJ,
  input wire logic [7:0] i_REQ_VAR,
  input wire logic [7:0] i_REQ_QUAL,
  input wire logic [7:0] i_REQ_START,
  input wire logic [7:0] i_REQ_STOP,
  input wire logic i_REQ_FIR,
  input wire logic i_REQ_FIN,
  input wire logic [7:0] i_CROB_CODE,
  input wire logic [7:0] i_CROB_COUNT,
  input wire logic [31:0] i_CROB_ON_MS,
  input wire logic [31:0] i_CROB_OFF_MS,
  input wire logic i_WRITE_VALUE,
  output logic o_REQ_READY,
  output logic o_RSP_VALID,
  input wire logic i_RSP_READY,
  output logic [1:0] o_RSP_KIND,
  output logic [7:0] o_RSP_OBJ,
  output logic [7:0] o_RSP_VAR,
  output logic [7:0] o_RSP_INDEX,
  output logic [31:0] o_RSP_DATA,
  output logic [1:0] o_RSP_STATUS,
  output logic o_ENERGY_CLEAR,
  input wire logic i_ENERGY_CLEAR_BUSY,
  output logic o_MODBUS_SELECT,
  output logic o_RESTART_FLAG,
  input wire logic i_OPEN_DELTA,
  input wire logic [15:0] i_HEALTH,
  input wire logic [2:0][31:0] i_VLN,
  input wire logic [2:0][31:0] i_VLL,
  input wire logic [2:0][31:0] i_CURRENT,
  input wire logic [2:0][31:0] i_POWER,
  input wire logic [15:0] i_PF,
  input wire logic [15:0] i_FREQ,
  input wire logic [4:0][31:0] i_DEMAND,
  input wire logic [5:0][15:0] i_ANGLE,
  input wire logic [5:0][15:0] i_RATIO,
  input wire logic [4:0][31:0] i_ENERGY
);
  // ************
  // Types and state
  // ************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HDR = 4'b0010,
    ST_PT = 4'b0100,
    ST_END = 4'b1000
  } state_e;

  state_e state;
  logic [1:0] group;
  logic class0;
  logic [7:0] cur_obj;
  logic [7:0] cur_var;
  logic [7:0] cur_idx;
  logic [7:0] cur_stop;
  logic modbus_select;
  logic energy_clear;
  logic restart_flag;
  logic [31:0][15:0] analog;
  logic [15:0] power_frac [8];
  logic [15:0] field_frac [9];
  logic crob_func_ok;
  logic crob_energy;
  logic crob_switch;
  logic req_take;
  logic frame_ok;
  logic rd_ok;
  logic rd_class0;
  logic [7:0] rd_obj;
  logic [7:0] rd_var;
  logic [7:0] rd_start;
  logic [7:0] rd_stop;
  logic iin_ok;

  // ************
  // Helper functions
  // ************
  // Default variation of each readable object, zero if not readable
  function automatic logic [7:0] default_var(input logic [7:0] obj);
    case (obj)
      OBJ_ANALOG: default_var = VAR_ANALOG;
      OBJ_COUNTER: default_var = VAR_COUNTER;
      OBJ_BIN_OUT: default_var = VAR_BIN_OUT;
      default: default_var = VAR_ANY;
    endcase
  endfunction

  // Highest point index served by each object
  function automatic logic [7:0] last_point(input logic [7:0] obj);
    case (obj)
      OBJ_ANALOG: last_point = LAST_ANALOG;
      OBJ_COUNTER: last_point = LAST_COUNTER;
      default: last_point = LAST_BIN_OUT;
    endcase
  endfunction

  // Class 0 object order: analog, then counters, then binary outputs
  function automatic logic [7:0] class0_obj(input logic [1:0] g);
    case (g)
      2'h0: class0_obj = OBJ_ANALOG;
      2'h1: class0_obj = OBJ_COUNTER;
      default: class0_obj = OBJ_BIN_OUT;
    endcase
  endfunction

  // Value of one point; analog points sign extended, others zero extended to the data word
  function automatic logic [31:0] point_value(input logic [7:0] obj,
                                              input logic [7:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (obj)
      OBJ_ANALOG: v = {{16{analog[idx[4:0]][15]}}, analog[idx[4:0]]};
      OBJ_COUNTER: v = (idx <= LAST_COUNTER) ? i_ENERGY[idx[2:0]] : 32'h0000_0000;
      OBJ_BIN_OUT: begin
        if (idx == 8'h00) begin
          v = {31'h0000_0000, energy_clear | i_ENERGY_CLEAR_BUSY};
        end else begin
          v = {31'h0000_0000, ~modbus_select};
        end
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ************
  // Analog scaling
  // ************
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_field
      frac_saturate u_vln (
        .i_value(i_VLN[gi]),
        .i_recip(RECIP_VLN),
        .o_frac(field_frac[gi])
      );
      frac_saturate u_vll (
        .i_value(i_VLL[gi]),
        .i_recip(RECIP_VLL),
        .o_frac(field_frac[gi + 3])
      );
      frac_saturate u_cur (
        .i_value(i_CURRENT[gi]),
        .i_recip(RECIP_CURRENT),
        .o_frac(field_frac[gi + 6])
      );
    end
    for (gi = 0; gi < 8; gi++) begin : g_power
      frac_saturate u_pwr (
        .i_value((gi < 3) ? i_POWER[gi % 3] : i_DEMAND[(gi + 2) % 5]),
        .i_recip(i_OPEN_DELTA ? RECIP_POWER_DELTA : RECIP_POWER),
        .o_frac(power_frac[gi])
      );
    end
  endgenerate

  // Point table; clamps applied to power factor, frequency and angle points
  always_comb begin
    analog = '0;
    analog[0] = i_HEALTH;
    for (int k = 0; k < 9; k++) begin
      analog[k + 1] = field_frac[k];
    end
    for (int k = 0; k < 3; k++) begin
      analog[k + 10] = power_frac[k];
    end
    for (int k = 0; k < 5; k++) begin
      analog[k + 15] = power_frac[k + 3];
    end
    if (i_OPEN_DELTA) begin
      analog[13] = 16'h0000;
    end else if ($signed(i_PF) > PF_MAX) begin
      analog[13] = PF_MAX;
    end else if ($signed(i_PF) < -PF_MAX) begin
      analog[13] = -PF_MAX;
    end else begin
      analog[13] = i_PF;
    end
    if (i_FREQ < FREQ_LOW) begin
      analog[14] = 16'h0000;
    end else if (i_FREQ > FREQ_HIGH) begin
      analog[14] = FREQ_PINNED;
    end else begin
      analog[14] = i_FREQ;
    end
    for (int k = 0; k < 6; k++) begin
      if ($signed(i_ANGLE[k]) > ANGLE_MAX) begin
        analog[k + 20] = ANGLE_MAX;
      end else if ($signed(i_ANGLE[k]) < -ANGLE_MAX) begin
        analog[k + 20] = -ANGLE_MAX;
      end else begin
        analog[k + 20] = i_ANGLE[k];
      end
      analog[k + 26] = i_RATIO[k];
    end
  end

  // ************
  // Request decode
  // ************
  crob_check u_crob (
    .i_func(i_REQ_FUNC),
    .i_point(i_REQ_START),
    .i_code(i_CROB_CODE),
    .i_count(i_CROB_COUNT),
    .i_on_ms(i_CROB_ON_MS),
    .i_off_ms(i_CROB_OFF_MS),
    .o_func_ok(crob_func_ok),
    .o_energy_reset(crob_energy),
    .o_proto_switch(crob_switch)
  );

  // Multi-frame requests cannot be reassembled here, so they are refused
  assign frame_ok = i_REQ_FIR & i_REQ_FIN;
  assign o_REQ_READY = (state == ST_IDLE);
  assign req_take = i_REQ_VALID & o_REQ_READY;
  assign iin_ok = (i_REQ_FUNC == FC_WRITE) && (i_REQ_VAR == VAR_IIN) &&
    (i_REQ_QUAL == QUAL_INDEX8) && (i_REQ_START == 8'h00);

  // Read qualification and variation resolution
  always_comb begin
    rd_class0 = (i_REQ_OBJ == OBJ_CLASS) &&
      ((i_REQ_VAR == VAR_ANY) || (i_REQ_VAR == VAR_CLASS0));
    rd_obj = rd_class0 ? class0_obj(2'h0) : i_REQ_OBJ;
    rd_var = default_var(rd_obj);
    rd_ok = rd_class0 || ((rd_var != VAR_ANY) &&
      ((i_REQ_VAR == VAR_ANY) || (i_REQ_VAR == rd_var)));
    rd_start = rd_class0 ? 8'h00 : i_REQ_START;
    rd_stop = (rd_class0 || i_REQ_STOP > last_point(rd_obj)) ?
      last_point(rd_obj) : i_REQ_STOP;
    if (rd_start > rd_stop) begin
      rd_ok = 1'b0;
    end
  end

  // ************
  // Response sequencing
  // ************
  // One item per accepted handshake; data taken at item load
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      state <= ST_IDLE;
      group <= 2'h0;
      class0 <= 1'b0;
      cur_obj <= 8'h00;
      cur_var <= 8'h00;
      cur_idx <= 8'h00;
      cur_stop <= 8'h00;
      o_RSP_KIND <= KIND_END;
      o_RSP_OBJ <= 8'h00;
      o_RSP_VAR <= 8'h00;
      o_RSP_INDEX <= 8'h00;
      o_RSP_DATA <= 32'h0000_0000;
      o_RSP_STATUS <= STATUS_OK;
    end else begin
      case (state)
        ST_IDLE: begin
          if (req_take) begin
            o_RSP_STATUS <= STATUS_OK;
            o_RSP_OBJ <= i_REQ_OBJ;
            o_RSP_VAR <= i_REQ_VAR;
            o_RSP_INDEX <= i_REQ_START;
            o_RSP_DATA <= 32'h0000_0000;
            o_RSP_KIND <= KIND_END;
            state <= ST_END;
            if (!frame_ok) begin
              o_RSP_STATUS <= STATUS_BAD_REQUEST;
            end else if (i_REQ_FUNC == FC_READ && rd_ok) begin
              class0 <= rd_class0;
              group <= 2'h0;
              cur_obj <= rd_obj;
              cur_var <= rd_var;
              cur_idx <= rd_start;
              cur_stop <= rd_stop;
              o_RSP_KIND <= KIND_HEADER;
              o_RSP_OBJ <= rd_obj;
              o_RSP_VAR <= rd_var;
              o_RSP_DATA <= {16'h0000, rd_start, rd_stop};
              state <= ST_HDR;
            end else if (i_REQ_OBJ == OBJ_CROB && crob_func_ok) begin
              if (crob_switch) begin
                state <= ST_IDLE;
              end else if (!crob_energy) begin
                o_RSP_STATUS <= STATUS_NOT_SUPPORTED;
              end
            end else if (i_REQ_OBJ == OBJ_IIN && iin_ok) begin
              o_RSP_STATUS <= STATUS_OK;
            end else begin
              o_RSP_STATUS <= STATUS_NOT_SUPPORTED;
            end
          end
        end
        ST_HDR: begin
          if (i_RSP_READY) begin
            o_RSP_KIND <= KIND_POINT;
            o_RSP_INDEX <= cur_idx;
            o_RSP_DATA <= point_value(cur_obj, cur_idx);
            state <= ST_PT;
          end
        end
        ST_PT: begin
          if (i_RSP_READY) begin
            if (cur_idx != cur_stop) begin
              cur_idx <= cur_idx + 8'h01;
              o_RSP_INDEX <= cur_idx + 8'h01;
              o_RSP_DATA <= point_value(cur_obj, cur_idx + 8'h01);
            end else if (class0 && group != LAST_CLASS0_GROUP) begin
              group <= group + 2'h1;
              cur_obj <= class0_obj(group + 2'h1);
              cur_var <= default_var(class0_obj(group + 2'h1));
              cur_idx <= 8'h00;
              cur_stop <= last_point(class0_obj(group + 2'h1));
              o_RSP_KIND <= KIND_HEADER;
              o_RSP_OBJ <= class0_obj(group + 2'h1);
              o_RSP_VAR <= default_var(class0_obj(group + 2'h1));
              o_RSP_DATA <= {24'h00_0000, last_point(class0_obj(group + 2'h1))};
              state <= ST_HDR;
            end else begin
              o_RSP_KIND <= KIND_END;
              o_RSP_DATA <= 32'h0000_0000;
              state <= ST_END;
            end
          end
        end
        ST_END: begin
          if (i_RSP_READY) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign o_RSP_VALID = (state != ST_IDLE);

  // ************
  // Actuation and indications
  // ************
  // Energy clear pulse; only the exact pulse shape reaches here
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      energy_clear <= 1'b0;
    end else begin
      energy_clear <= req_take && frame_ok && (i_REQ_OBJ == OBJ_CROB) &&
        crob_energy;
    end
  end

  // Temporary switch; no stored setting is touched, reset undoes it
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      modbus_select <= 1'b0;
    end else if (req_take && frame_ok && (i_REQ_OBJ == OBJ_CROB) && crob_switch) begin
      modbus_select <= 1'b1;
    end
  end

  // Restart indication: set by reset, cleared only by a zero write
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      restart_flag <= 1'b1;
    end else if (req_take && frame_ok && (i_REQ_OBJ == OBJ_IIN) && iin_ok &&
                 !i_WRITE_VALUE) begin
      restart_flag <= 1'b0;
    end
  end

  assign o_ENERGY_CLEAR = energy_clear;
  assign o_MODBUS_SELECT = modbus_select;
  assign o_RESTART_FLAG = restart_flag;
endmodule

// [hdl/dnp_resp_pkg.sv]
// Purpose: shared constants of the meter object responder
// Assumes: requests arrive already parsed from link and transport layers
// Notes: analog inputs arrive as Q10 secondary units (value * 1024)
package dnp_resp_pkg;
  // ************
  // Function codes and objects
  // ************
  localparam logic [7:0] FC_READ = 8'h01;
  localparam logic [7:0] FC_WRITE = 8'h02;
  localparam logic [7:0] FC_DIRECT_OP = 8'h05;
  localparam logic [7:0] FC_DIRECT_OP_NOACK = 8'h06;
  localparam logic [7:0] OBJ_BIN_OUT = 8'h0A;
  localparam logic [7:0] OBJ_CROB = 8'h0C;
  localparam logic [7:0] OBJ_COUNTER = 8'h14;
  localparam logic [7:0] OBJ_ANALOG = 8'h1E;
  localparam logic [7:0] OBJ_CLASS = 8'h3C;
  localparam logic [7:0] OBJ_IIN = 8'h50;
  localparam logic [7:0] VAR_ANY = 8'h00;
  localparam logic [7:0] VAR_BIN_OUT = 8'h02;
  localparam logic [7:0] VAR_COUNTER = 8'h04;
  localparam logic [7:0] VAR_ANALOG = 8'h05;
  localparam logic [7:0] VAR_CLASS0 = 8'h01;
  localparam logic [7:0] VAR_IIN = 8'h01;
  localparam logic [7:0] QUAL_INDEX8 = 8'h00;
  localparam logic [7:0] LAST_BIN_OUT = 8'h01;
  localparam logic [7:0] LAST_COUNTER = 8'h04;
  localparam logic [7:0] LAST_ANALOG = 8'h1F;
  localparam logic [1:0] LAST_CLASS0_GROUP = 2'h2;
  // ************
  // Control relay pulse parameters
  // ************
  localparam logic [7:0] CROB_PULSE_ON = 8'h01;
  localparam logic [7:0] CROB_COUNT_ONE = 8'h01;
  localparam logic [31:0] CROB_ON_MS = 32'h0000_0001;
  localparam logic [31:0] CROB_OFF_MS = 32'h0000_0000;
  localparam logic [7:0] PT_ENERGY_RESET = 8'h00;
  localparam logic [7:0] PT_PROTO_SWITCH = 8'h01;
  // ************
  // Analog scaling
  // ************
  localparam int FRAC_SHIFT = 20;
  localparam int FS_VLN_V = 150;
  localparam int FS_VLL_V = 300;
  localparam int FS_CURRENT_A = 10;
  localparam int FS_POWER_W = 4500;
  localparam int FS_POWER_DELTA_W = 3000;
  // Reciprocal of full scale: 2^35 / (fs * 1024) = 2^25 / fs
  localparam logic [23:0] RECIP_VLN = 24'(33554432 / FS_VLN_V);
  localparam logic [23:0] RECIP_VLL = 24'(33554432 / FS_VLL_V);
  localparam logic [23:0] RECIP_CURRENT = 24'(33554432 / FS_CURRENT_A);
  localparam logic [23:0] RECIP_POWER = 24'(33554432 / FS_POWER_W);
  localparam logic [23:0] RECIP_POWER_DELTA = 24'(33554432 / FS_POWER_DELTA_W);
  localparam logic signed [15:0] FRAC_MAX = 16'sh7FFF;
  localparam logic signed [15:0] FRAC_MIN = -16'sh7FFF;
  localparam logic signed [15:0] PF_MAX = 16'sh03E8;
  localparam logic signed [15:0] ANGLE_MAX = 16'sh0708;
  localparam logic [15:0] FREQ_LOW = 16'h1194;
  localparam logic [15:0] FREQ_HIGH = 16'h1D4C;
  localparam logic [15:0] FREQ_PINNED = 16'h270F;
  // ************
  // Response stream
  // ************
  localparam logic [1:0] KIND_HEADER = 2'h0;
  localparam logic [1:0] KIND_POINT = 2'h1;
  localparam logic [1:0] KIND_END = 2'h2;
  localparam logic [1:0] STATUS_OK = 2'h0;
  localparam logic [1:0] STATUS_NOT_SUPPORTED = 2'h1;
  localparam logic [1:0] STATUS_BAD_REQUEST = 2'h2;
endpackage

// [hdl/frac_saturate.sv]
// Purpose: scale a Q10 secondary value to a saturated 16-bit fraction
// Assumes: reciprocal is 2^25 / full scale
// Notes: purely combinational
`timescale 1ns/100ps
module frac_saturate
  import dnp_resp_pkg::*;
(
  input wire logic signed [31:0] i_value,
  input wire logic [23:0] i_recip,
  output logic signed [15:0] o_frac
);
  logic signed [56:0] product;
  logic signed [56:0] scaled;

  // Multiply by reciprocal, then pin at plus or minus full scale
  always_comb begin
    product = 57'(i_value) * 57'($signed({1'b0, i_recip}));
    scaled = product >>> FRAC_SHIFT;
    if (scaled > 57'(FRAC_MAX)) begin
      o_frac = FRAC_MAX;
    end else if (scaled < 57'(FRAC_MIN)) begin
      o_frac = FRAC_MIN;
    end else begin
      o_frac = scaled[15:0];
    end
  end
endmodule

// [hdl/crob_check.sv]
// Purpose: qualify a control relay output request
// Assumes: fields already parsed from the request
// Notes: combinational; a mismatch never actuates
`timescale 1ns/100ps
module crob_check
  import dnp_resp_pkg::*;
(
  input wire logic [7:0] i_func,
  input wire logic [7:0] i_point,
  input wire logic [7:0] i_code,
  input wire logic [7:0] i_count,
  input wire logic [31:0] i_on_ms,
  input wire logic [31:0] i_off_ms,
  output logic o_func_ok,
  output logic o_energy_reset,
  output logic o_proto_switch
);
  logic pulse_ok;

  // Only one exact pulse shape is honoured
  always_comb begin
    pulse_ok = (i_code == CROB_PULSE_ON) && (i_count == CROB_COUNT_ONE) &&
      (i_on_ms == CROB_ON_MS) && (i_off_ms == CROB_OFF_MS);
    o_func_ok = (i_func == FC_DIRECT_OP) || (i_func == FC_DIRECT_OP_NOACK);
    o_energy_reset = pulse_ok && (i_func == FC_DIRECT_OP) &&
      (i_point == PT_ENERGY_RESET);
    o_proto_switch = pulse_ok && (i_func == FC_DIRECT_OP_NOACK) &&
      (i_point == PT_PROTO_SWITCH);
  end
endmodule

// [tb/dnp_resp_sva.sv]
// Purpose: port checker of the object responder
// Assumes: sees only the top ports; one clock domain
// Notes: bound to every instance of the responder below
`timescale 1ns/100ps
module dnp_resp_sva
  import dnp_resp_pkg::*;
(
  input logic I_CORE_CLK,
  input logic I_RESET,
  input logic i_REQ_VALID,
  input logic [7:0] i_REQ_FUNC,
  input logic [7:0] i_REQ_OBJ,
  input logic [7:0] i_REQ_VAR,
  input logic [7:0] i_REQ_QUAL,
  input logic [7:0] i_REQ_START,
  input logic i_REQ_FIR,
  input logic i_REQ_FIN,
  input logic [7:0] i_CROB_CODE,
  input logic [7:0] i_CROB_COUNT,
  input logic [31:0] i_CROB_ON_MS,
  input logic [31:0] i_CROB_OFF_MS,
  input logic i_WRITE_VALUE,
  input logic o_REQ_READY,
  input logic o_RSP_VALID,
  input logic i_RSP_READY,
  input logic [1:0] o_RSP_KIND,
  input logic [7:0] o_RSP_OBJ,
  input logic [7:0] o_RSP_VAR,
  input logic [7:0] o_RSP_INDEX,
  input logic [1:0] o_RSP_STATUS,
  input logic o_ENERGY_CLEAR,
  input logic o_MODBUS_SELECT,
  input logic o_RESTART_FLAG
);
  // Whole-frame request taken, and an exact pulse block
  logic take;
  logic pulse_ok;
  assign take = i_REQ_VALID && o_REQ_READY && i_REQ_FIR && i_REQ_FIN;
  assign pulse_ok = i_CROB_CODE == CROB_PULSE_ON && i_CROB_COUNT == CROB_COUNT_ONE
    && i_CROB_ON_MS == CROB_ON_MS && i_CROB_OFF_MS == CROB_OFF_MS;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);
  property p_clear_cause;
    o_ENERGY_CLEAR |-> $past(take && pulse_ok && i_REQ_FUNC == FC_DIRECT_OP
      && i_REQ_OBJ == OBJ_CROB && i_REQ_START == PT_ENERGY_RESET);
  endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("energy clear without cause");
  property p_clear_once;
    o_ENERGY_CLEAR |=> !o_ENERGY_CLEAR;
  endproperty
  a_clear_once: assert property (p_clear_once) else $error("energy clear too long");
  property p_switch_cause;
    $rose(o_MODBUS_SELECT) |-> $past(take && pulse_ok && i_REQ_FUNC == FC_DIRECT_OP_NOACK
      && i_REQ_OBJ == OBJ_CROB && i_REQ_START == PT_PROTO_SWITCH);
  endproperty
  a_switch_cause: assert property (p_switch_cause) else $error("switch without cause");
  property p_switch_holds;
    o_MODBUS_SELECT |=> o_MODBUS_SELECT;
  endproperty
  a_switch_holds: assert property (p_switch_holds) else $error("switch dropped");
  property p_restart_set;
    disable iff (1'b0) I_RESET |=> o_RESTART_FLAG;
  endproperty
  a_restart_set: assert property (p_restart_set) else $error("restart not set");
  property p_restart_clear;
    $fell(o_RESTART_FLAG) |-> $past(take && i_REQ_FUNC == FC_WRITE && i_REQ_OBJ == OBJ_IIN
      && i_REQ_QUAL == QUAL_INDEX8 && !i_WRITE_VALUE);
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart cleared");
  property p_crob_func;
    take && i_REQ_OBJ == OBJ_CROB && i_REQ_FUNC != FC_DIRECT_OP
      && i_REQ_FUNC != FC_DIRECT_OP_NOACK |=> o_RSP_VALID && o_RSP_KIND == KIND_END
      && o_RSP_STATUS == STATUS_NOT_SUPPORTED && !o_ENERGY_CLEAR;
  endproperty
  a_crob_func: assert property (p_crob_func) else $error("control function taken");
  property p_bad_pulse;
    take && i_REQ_OBJ == OBJ_CROB && !pulse_ok |=> o_RSP_VALID && !o_ENERGY_CLEAR
      && !$rose(o_MODBUS_SELECT) && o_RSP_STATUS == STATUS_NOT_SUPPORTED;
  endproperty
  a_bad_pulse: assert property (p_bad_pulse) else $error("bad pulse acted");
  property p_frame;
    i_REQ_VALID && o_REQ_READY && !(i_REQ_FIR && i_REQ_FIN) |=> o_RSP_VALID
      && o_RSP_KIND == KIND_END && o_RSP_STATUS == STATUS_BAD_REQUEST;
  endproperty
  a_frame: assert property (p_frame) else $error("split frame taken");
  property p_class0;
    take && i_REQ_FUNC == FC_READ && i_REQ_OBJ == OBJ_CLASS && i_REQ_VAR == VAR_ANY
      |=> o_RSP_KIND == KIND_HEADER && o_RSP_OBJ == OBJ_ANALOG && o_RSP_VAR == VAR_ANALOG;
  endproperty
  a_class0: assert property (p_class0) else $error("class read order");
  property p_stand;
    o_RSP_VALID && !i_RSP_READY |=> o_RSP_VALID && $stable(o_RSP_KIND)
      && $stable(o_RSP_INDEX);
  endproperty
  a_stand: assert property (p_stand) else $error("item not held");
endmodule

bind dnp_object_responder dnp_resp_sva dnp_resp_sva_inst (.*);

// [tb/dnp_master_model.sv]
// Purpose: master station stand-in issuing parsed requests
// Assumes: lines change at the falling edge, held until taken
// Notes: released lines show inverted values; frame flags keep their last values
`timescale 1ns/100ps
module dnp_master_model
  import dnp_resp_pkg::*;
(
  input logic i_clk,
  input logic i_req_ready,
  input logic i_slow,
  output logic o_valid,
  output logic [7:0] o_func,
  output logic [7:0] o_obj,
  output logic [7:0] o_var,
  output logic [7:0] o_qual,
  output logic [7:0] o_start,
  output logic [7:0] o_stop,
  output logic o_fir,
  output logic o_fin,
  output logic [7:0] o_code,
  output logic [7:0] o_count,
  output logic [31:0] o_on_ms,
  output logic [31:0] o_off_ms,
  output logic o_write_value,
  output logic o_rsp_ready
);
  // Fixed fields: indexing, pulse code, on and off times, and write value
  assign o_qual = QUAL_INDEX8;
  assign o_code = CROB_PULSE_ON;
  assign o_on_ms = CROB_ON_MS;
  assign o_off_ms = CROB_OFF_MS;
  assign o_write_value = 1'b0;
  // Idle lines at time zero
  initial begin
    o_valid = 1'b0;
    o_rsp_ready = 1'b1;
    {o_func, o_obj, o_var, o_start, o_stop, o_fir, o_fin, o_count} = '0;
  end
  // Slow mode stalls every other cycle
  always @(negedge i_clk) begin
    o_rsp_ready <= i_slow ? ~o_rsp_ready : 1'b1;
  end
  // One request, held until the edge that takes it
  task automatic send(input logic [7:0] f, o, v, s, e, input logic [1:0] fr,
                      input logic [7:0] c, output logic hung);
    int n;
    @(negedge i_clk);
    {o_func, o_obj, o_var, o_start, o_stop, o_count} = {f, o, v, s, e, c};
    {o_fir, o_fin} = fr;
    o_valid = 1'b1;
    #1;
    for (n = 0; n < 50 && !i_req_ready; n++) begin
      @(negedge i_clk);
      #1;
    end
    hung = (n == 50);
    @(negedge i_clk);
    o_valid = 1'b0;
    {o_func, o_obj, o_var, o_start, o_stop, o_count} = ~{f, o, v, s, e, c};
  endtask
endmodule

// [tb/dnp_object_responder_tb.sv]
// Purpose: self-checking bench of the object responder
// Assumes: master model drives requests at the falling edge
// Notes: datapath words share one value, except health, line-to-neutral voltages and energy
`timescale 1ns/100ps
module dnp_object_responder_tb
  import dnp_resp_pkg::*;
;
  logic clk, rst, busy, slow, hung, clr;
  logic [15:0] health;
  logic [31:0] dp;
  logic [2:0][31:0] vln;
  logic [4:0][31:0] energy;
  wire logic valid, rdy, fir, fin, rv, rr, eclr, mb, rf, wv;
  wire logic [7:0] f, o, v, q, s, e, code, cnt, ro, rvar;
  wire logic [31:0] onms, offms, rd;
  wire logic [1:0] rk, rs;
  int num_errors, samples_checked, got;
  logic [1:0] kd [64];
  logic [7:0] ob [64];
  logic [7:0] va [64];
  logic [31:0] da [64];
  logic [1:0] st;
  dnp_master_model dnp_master_model_inst (.i_clk(clk), .i_req_ready(rdy), .i_slow(slow),
    .o_valid(valid), .o_func(f), .o_obj(o), .o_var(v), .o_qual(q), .o_start(s), .o_stop(e),
    .o_fir(fir), .o_fin(fin), .o_code(code), .o_count(cnt), .o_on_ms(onms),
    .o_off_ms(offms), .o_write_value(wv), .o_rsp_ready(rr));
  dnp_object_responder dnp_object_responder_inst (.I_CORE_CLK(clk), .I_RESET(rst),
    .i_REQ_VALID(valid), .i_REQ_FUNC(f), .i_REQ_OBJ(o), .i_REQ_VAR(v), .i_REQ_QUAL(q),
    .i_REQ_START(s), .i_REQ_STOP(e), .i_REQ_FIR(fir), .i_REQ_FIN(fin), .i_CROB_CODE(code),
    .i_CROB_COUNT(cnt), .i_CROB_ON_MS(onms), .i_CROB_OFF_MS(offms), .i_WRITE_VALUE(wv),
    .o_REQ_READY(rdy), .o_RSP_VALID(rv), .i_RSP_READY(rr), .o_RSP_KIND(rk), .o_RSP_OBJ(ro),
    .o_RSP_VAR(rvar), .o_RSP_INDEX(), .o_RSP_DATA(rd), .o_RSP_STATUS(rs),
    .o_ENERGY_CLEAR(eclr), .i_ENERGY_CLEAR_BUSY(busy), .o_MODBUS_SELECT(mb),
    .o_RESTART_FLAG(rf), .i_OPEN_DELTA(dp[0]), .i_HEALTH(health), .i_VLN(vln),
    .i_VLL({3{dp}}), .i_CURRENT({3{dp}}), .i_POWER({3{dp}}), .i_PF(dp[15:0]),
    .i_FREQ(dp[15:0]), .i_DEMAND({5{dp}}), .i_ANGLE({6{dp[15:0]}}),
    .i_RATIO({6{dp[15:0]}}), .i_ENERGY(energy));
  // Free-running 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // Send, gather items to END; bounded
  task automatic req(input logic [7:0] fx, ox, vx, sx, ex, input logic [1:0] fr,
                     input logic [7:0] cx);
    int n;
    dnp_master_model_inst.send(fx, ox, vx, sx, ex, fr, cx, hung);
    got = 0;
    clr = 1'b0;
    for (n = 0; n < 300 && !hung; n++) begin
      #1;
      clr = clr | eclr;
      if (rv && rr && got < 64) begin
        {kd[got], ob[got], va[got], da[got], st} = {rk, ro, rvar, rd, rs};
        got++;
        if (rk === KIND_END) break;
      end
      @(negedge clk);
    end
    if (hung || n == 300) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic refuse(input logic [7:0] fx, sx, cx);
    req(fx, OBJ_CROB, 8'h01, sx, sx, 2'b11, cx);
    chk(32'(clr), 0);
    chk(32'(st), 32'(STATUS_NOT_SUPPORTED));
    chk(32'(mb), 0);
  endtask
  task automatic t_control();
    chk(32'(rf), 1);
    busy = 1'b1;
    req(FC_DIRECT_OP, OBJ_CROB, 8'h01, PT_ENERGY_RESET, 8'h00, 2'b11, CROB_COUNT_ONE);
    chk(32'(clr), 1);
    chk(32'(st), 32'(STATUS_OK));
    req(FC_READ, OBJ_BIN_OUT, VAR_ANY, 8'h00, 8'h01, 2'b11, 8'h00);
    chk(da[1], 1);
    chk(da[2], 1);
    busy = 1'b0;
    refuse(FC_DIRECT_OP, PT_ENERGY_RESET, 8'h02);
    refuse(FC_DIRECT_OP, PT_PROTO_SWITCH, CROB_COUNT_ONE);
    refuse(FC_DIRECT_OP_NOACK, PT_ENERGY_RESET, CROB_COUNT_ONE);
    refuse(FC_READ, PT_ENERGY_RESET, CROB_COUNT_ONE);
    req(FC_READ, OBJ_ANALOG, VAR_ANY, 8'h00, 8'h00, 2'b01, 8'h00);
    chk(32'(st), 32'(STATUS_BAD_REQUEST));
    $display("control done");
  endtask
  task automatic t_reads();
    vln = {32'h0000_0400, 32'hFFFC_E000, 32'h0003_2000};
    slow = 1'b1;
    req(FC_READ, OBJ_ANALOG, VAR_ANY, 8'h00, 8'h02, 2'b11, 8'h00);
    chk(32'(va[0]), 32'(VAR_ANALOG));
    chk(da[1], 32'h0000_0005);
    chk(da[2], 32'h0000_7FFF);
    chk(da[3], 32'hFFFF_8001);
    slow = 1'b0;
    req(FC_READ, OBJ_COUNTER, VAR_ANY, 8'h04, 8'h04, 2'b11, 8'h00);
    chk(32'(va[0]), 32'(VAR_COUNTER));
    chk(da[1], 32'h1234_5678);
    req(FC_READ, OBJ_CLASS, VAR_ANY, 8'h00, 8'h00, 2'b11, 8'h00);
    chk(32'(got), 43);
    chk({ob[0], ob[33], ob[39], va[33]}, {OBJ_ANALOG, OBJ_COUNTER, OBJ_BIN_OUT, VAR_COUNTER});
    chk(32'(st), 32'(STATUS_OK));
    $display("reads done");
  endtask
  task automatic t_restart();
    req(FC_WRITE, OBJ_IIN, VAR_IIN, 8'h00, 8'h00, 2'b11, 8'h00);
    chk(32'(st), 32'(STATUS_OK));
    chk(32'(rf), 0);
    dnp_master_model_inst.send(FC_DIRECT_OP_NOACK, OBJ_CROB, 8'h01, PT_PROTO_SWITCH,
                               PT_PROTO_SWITCH, 2'b11, CROB_COUNT_ONE, hung);
    chk(32'(hung), 0);
    repeat (2) @(negedge clk);
    chk(32'(mb), 1);
    chk(32'(rv), 0);
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk({30'h0, mb, rf}, 1);
    $display("restart done");
  endtask
  // Main sequence
  initial begin
    {rst, busy, slow, health, dp} = {3'b100, 16'h0005, 32'h0000_0400};
    vln = '0;
    energy = {32'h1234_5678, 128'h0};
    num_errors = 0;
    samples_checked = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_control();
    t_reads();
    t_restart();
    conclude();
  end
endmodule
